/* File: core/ptp_ctrl_defs.vh */
// Operation
// - Unicast enable recognises unicast PTP frames
// - Alternate master also forwards master Sync to host
// - Priority bit sends all PTP to top
// - Three association enables forward matching frames
// - Drop enable discards sync without master
// - Domain check forwards match, drops mismatch
// - Checksum enable recomputes, else writes zero
// - Zero IPv4 checksum stays; IPv6 updated
// - Version field default 2 compared, mismatch dropped
// - Domain field gates capture when checking
// - Index register selects stamp/trigger unit
// - Error bit set on late target
// - Done bit set on output, W1C
// - Global status is OR of unit bits
// - Notify and stamp irq enable gate status
// - Pin source, live input, pin role bits
// - Active bit shows enabled running unit
// - Trigger enable starts, self-clears when generated
// - Trigger soft clear returns unit inactive
// - Stamp enable write clears count or flags
// - Stamp soft clear returns unit inactive
// - Target time 30-bit ns, 32-bit s
`ifndef PTP_CTRL_DEFS_VH
`define PTP_CTRL_DEFS_VH
`define OFF_MSG_CFG2     12'h516
`define OFF_DOM_VER      12'h518
`define OFF_UNIT_INDEX   12'h520
`define OFF_TRIG_STATUS  12'h524
`define OFF_IRQ_STATUS   12'h528
`define OFF_CONTROL      12'h52C
`define OFF_TARGET_NS    12'h530
`define OFF_TARGET_S     12'h534
`define OFF_TRIG_NOTIFY  12'h538
`define OFF_STAMP_EVENT  12'h550
`define MSG_CFG2_RESET   16'h1004
`define DOM_VER_RESET    16'h0200
`define BIT_UNICAST      12
`define BIT_ALT_MASTER   11
`define BIT_ALL_PRIO     10
`define BIT_ASSOC_SYNC   9
`define BIT_ASSOC_DELAY  8
`define BIT_ASSOC_PDELAY 7
`define BIT_DROP_NO_BMC  5
`define BIT_DOMAIN_CHECK 4
`define BIT_CSUM_CALC    2
`define BIT_PIN_OUT_SEL  8
`define BIT_PIN_IN       7
`define BIT_PIN_ROLE     6
`define BIT_STAMP_IRQ    5
`define BIT_TRIG_ACTIVE  4
`define BIT_TRIG_ENABLE  3
`define BIT_TRIG_CLEAR   2
`define BIT_STAMP_ENABLE 1
`define BIT_STAMP_CLEAR  0
`define BIT_STAMP_SEL    8
`define STAMP_COUNT_MAX  4'hF
`endif

/* File: core/ptp_global_control_regs.v */
`default_nettype none
`include "ptp_ctrl_defs.vh"
module ptp_global_control_regs (
   input  wire        SYS_CLK_I,
   input  wire        RST_N_I,
   input  wire [11:0] ADDR_I,
   input  wire [31:0] WDATA_I,
   input  wire        WR_I,
   input  wire        RD_I,
   output reg  [31:0] RDATA_O,
   // Pin, time, frame classifier, stamp event and interrupt facing
   input  wire        PIN_IN_I,
   input  wire [63:0] SYS_TIME_I,
   input  wire        BMC_KNOWN_I,
   input  wire        FRAME_VALID_I,
   input  wire        FRAME_IS_MCAST_I,
   input  wire        FRAME_RESERVED_ADDR_I,
   input  wire [15:0] FRAME_UDP_PORT_I,
   input  wire [3:0]  FRAME_MSG_TYPE_I,
   input  wire [3:0]  FRAME_VERSION_I,
   input  wire [7:0]  FRAME_DOMAIN_I,
   input  wire        FRAME_FROM_HOST_I,
   input  wire        FRAME_FROM_MASTER_I,
   input  wire        FRAME_ASSOC_MATCH_I,
   input  wire        FRAME_IS_IPV6_I,
   input  wire        FRAME_MODIFIED_I,
   input  wire        FRAME_CSUM_ZERO_I,
   input  wire [1:0]  STAMP_EVENT_I,
   output reg         IS_PTP_O,
   output reg         DROP_O,
   output reg         TO_HOST_O,
   output reg         TO_NONHOST_O,
   output reg         TOP_QUEUE_O,
   output reg         CAPTURE_O,
   output reg         CSUM_RECALC_O,
   output reg         CSUM_ZERO_O,
   output reg         PIN_OUT_O,
   output reg         PIN_OE_O,
   output reg         PIN_OUT_SEL_O,
   output reg         GLOBAL_IRQ_STATUS_O
);

   localparam [15:0] PTP_EVENT_PORT = 16'd319;
   localparam [15:0] PTP_GEN_PORT   = 16'd320;
   localparam [3:0]  MSG_SYNC       = 4'h0;
   localparam [3:0]  MSG_DELAY_REQ  = 4'h1;
   localparam [3:0]  MSG_FOLLOW_UP  = 4'h8;

   reg [15:0] msg_cfg2;
   reg [3:0]  ptp_version;
   reg [7:0]  domain_match_value;
   reg [1:0]  trigger_unit_select;
   reg        stamp_unit_select;
   reg [2:0]  trig_done;
   reg [2:0]  trig_error;
   reg [2:0]  trig_irq;
   reg [1:0]  stamp_irq;
   reg        pin_out_sel;
   reg        pin_role_select;
   reg [1:0]  stamp_irq_enable;
   reg [2:0]  trig_enable;
   reg [2:0]  trig_notify;
   reg [1:0]  stamp_unit_enable;
   reg [7:0]  stamp_event_count;
   reg [1:0]  stamp_ready_flag;
   reg [1:0]  stamp_count_overflow;
   reg [29:0] target_ns [0:2];
   reg [31:0] target_s  [0:2];
   reg        pin_level;
   reg [31:0] next_rdata;
   reg        next_drop;
   reg        next_to_host;
   reg        next_is_ptp;
   reg        late;
   reg        due;
   integer    u;

   wire ts = stamp_unit_select;
   wire [1:0] tu = trigger_unit_select;
   wire tu_ok = (tu != 2'b11);
   wire [31:0] tsec = tu_ok ? target_s[tu] : 32'h00000000;
   wire [29:0] tnsv = tu_ok ? target_ns[tu] : 30'h00000000;
   wire [63:0] target = {tsec, 2'b00, tnsv};

   function [3:0] cnt_of;
      input [7:0] c;
      input       s;
      begin
         cnt_of = s ? c[7:4] : c[3:0];
      end
   endfunction

   wire port_hit = (FRAME_UDP_PORT_I == PTP_EVENT_PORT) || (FRAME_UDP_PORT_I == PTP_GEN_PORT);
   wire unicast  = msg_cfg2[`BIT_UNICAST] && port_hit && !FRAME_RESERVED_ADDR_I;
   wire is_sync  = (FRAME_MSG_TYPE_I == MSG_SYNC) || (FRAME_MSG_TYPE_I == MSG_DELAY_REQ);
   wire is_event = !FRAME_MSG_TYPE_I[3];
   wire dom_eq   = (FRAME_DOMAIN_I == domain_match_value);

   always @* begin
      next_is_ptp = FRAME_VALID_I && ((FRAME_IS_MCAST_I && port_hit) || unicast);
      next_drop   = 1'b0;
      next_to_host = !FRAME_FROM_HOST_I;
      if (FRAME_VERSION_I != ptp_version)
         next_drop = 1'b1;
      if (msg_cfg2[`BIT_DROP_NO_BMC] && !BMC_KNOWN_I
          && (is_sync || FRAME_MSG_TYPE_I == MSG_FOLLOW_UP))
         next_drop = 1'b1;
      if (msg_cfg2[`BIT_DOMAIN_CHECK] && !dom_eq)
         next_drop = 1'b1;
      if (!msg_cfg2[`BIT_ALT_MASTER] && is_sync && FRAME_FROM_MASTER_I && dom_eq)
         next_to_host = 1'b0;
      if (FRAME_ASSOC_MATCH_I && (msg_cfg2[`BIT_ASSOC_SYNC] || msg_cfg2[`BIT_ASSOC_DELAY]
          || msg_cfg2[`BIT_ASSOC_PDELAY]))
         next_to_host = 1'b1;
      if (!next_is_ptp)
         next_drop = 1'b0;
   end

   always @* begin
      next_rdata = 32'h00000000;
      if (ADDR_I == `OFF_MSG_CFG2) begin
         next_rdata = {16'h0000, msg_cfg2};
      end else if (ADDR_I == `OFF_DOM_VER) begin
         next_rdata = {20'h00000, ptp_version, domain_match_value};
      end else if (ADDR_I == `OFF_UNIT_INDEX) begin
         next_rdata = {23'h000000, stamp_unit_select, 6'h00, trigger_unit_select};
      end else if (ADDR_I == `OFF_TRIG_STATUS) begin
         next_rdata = {13'h0000, trig_error, 13'h0000, trig_done};
      end else if (ADDR_I == `OFF_IRQ_STATUS) begin
         next_rdata = {13'h0000, trig_irq, 14'h0000, stamp_irq};
      end else if (ADDR_I == `OFF_CONTROL) begin
         next_rdata[`BIT_PIN_OUT_SEL] = pin_out_sel;
         next_rdata[`BIT_PIN_IN]      = pin_level;
         next_rdata[`BIT_PIN_ROLE]    = pin_role_select;
         next_rdata[`BIT_STAMP_IRQ]   = stamp_irq_enable[ts];
         next_rdata[`BIT_TRIG_ACTIVE] = tu_ok && trig_enable[tu] && !trig_error[tu];
         next_rdata[`BIT_TRIG_ENABLE] = tu_ok && trig_enable[tu];
         next_rdata[`BIT_STAMP_ENABLE] = stamp_unit_enable[ts];
      end else if (ADDR_I == `OFF_TARGET_NS) begin
         next_rdata = {2'b00, tnsv};
      end else if (ADDR_I == `OFF_TARGET_S) begin
         next_rdata = tsec;
      end else if (ADDR_I == `OFF_TRIG_NOTIFY) begin
         next_rdata[24] = tu_ok && trig_notify[tu];
      end else if (ADDR_I == `OFF_STAMP_EVENT) begin
         next_rdata = {11'h000, cnt_of(stamp_event_count, ts), stamp_count_overflow[ts], 16'h0000};
         next_rdata[15] = stamp_ready_flag[ts];
      end
   end

   always @* begin
      late = (target < SYS_TIME_I);
      due  = (target <= SYS_TIME_I);
   end

   wire wr_ctl = WR_I && (ADDR_I == `OFF_CONTROL);

   always @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         msg_cfg2 <= `MSG_CFG2_RESET;
         ptp_version <= 4'h2;
         domain_match_value <= 8'h00;
         trigger_unit_select <= 2'b00;
         stamp_unit_select <= 1'b0;
         trig_done <= 3'b000;
         trig_error <= 3'b000;
         trig_irq <= 3'b000;
         stamp_irq <= 2'b00;
         pin_out_sel <= 1'b0;
         pin_role_select <= 1'b0;
         stamp_irq_enable <= 2'b00;
         trig_enable <= 3'b000;
         trig_notify <= 3'b000;
         stamp_unit_enable <= 2'b00;
         stamp_event_count <= 8'h00;
         stamp_ready_flag <= 2'b00;
         stamp_count_overflow <= 2'b00;
         for (u = 0; u < 3; u = u + 1) begin
            target_ns[u] <= 30'h00000000;
            target_s[u] <= 32'h00000000;
         end
         pin_level <= 1'b0;
         RDATA_O <= 32'h00000000;
         IS_PTP_O <= 1'b0;
         DROP_O <= 1'b0;
         TO_HOST_O <= 1'b0;
         TO_NONHOST_O <= 1'b0;
         TOP_QUEUE_O <= 1'b0;
         CAPTURE_O <= 1'b0;
         CSUM_RECALC_O <= 1'b0;
         CSUM_ZERO_O <= 1'b0;
         PIN_OUT_O <= 1'b0;
         PIN_OE_O <= 1'b0;
         PIN_OUT_SEL_O <= 1'b0;
         GLOBAL_IRQ_STATUS_O <= 1'b0;
      end else begin
         pin_level <= PIN_IN_I;
         if (RD_I)
            RDATA_O <= next_rdata;
         IS_PTP_O <= next_is_ptp;
         DROP_O <= next_drop;
         TO_HOST_O <= next_is_ptp && !next_drop && next_to_host;
         TO_NONHOST_O <= next_is_ptp && !next_drop;
         TOP_QUEUE_O <= next_is_ptp && (msg_cfg2[`BIT_ALL_PRIO] || is_event);
         CAPTURE_O <= next_is_ptp && !next_drop
                      && (!msg_cfg2[`BIT_DOMAIN_CHECK] || dom_eq);
         CSUM_RECALC_O <= FRAME_VALID_I && FRAME_MODIFIED_I && (FRAME_IS_IPV6_I
                          || (msg_cfg2[`BIT_CSUM_CALC] && !FRAME_CSUM_ZERO_I));
         CSUM_ZERO_O <= FRAME_VALID_I && FRAME_MODIFIED_I && !FRAME_IS_IPV6_I
                        && (!msg_cfg2[`BIT_CSUM_CALC] || FRAME_CSUM_ZERO_I);
         PIN_OE_O <= pin_role_select;
         PIN_OUT_SEL_O <= pin_out_sel;
         PIN_OUT_O <= pin_role_select && tu_ok && trig_done[tu];
         GLOBAL_IRQ_STATUS_O <= |{trig_irq, stamp_irq};
         if (WR_I) begin
            if (ADDR_I == `OFF_MSG_CFG2) begin
               msg_cfg2 <= {3'b000, WDATA_I[12:0]};
            end else if (ADDR_I == `OFF_DOM_VER) begin
               ptp_version <= WDATA_I[11:8];
               domain_match_value <= WDATA_I[7:0];
            end else if (ADDR_I == `OFF_UNIT_INDEX) begin
               stamp_unit_select <= WDATA_I[`BIT_STAMP_SEL];
               trigger_unit_select <= WDATA_I[1:0];
            end else if (ADDR_I == `OFF_CONTROL) begin
               pin_out_sel <= WDATA_I[`BIT_PIN_OUT_SEL];
               pin_role_select <= WDATA_I[`BIT_PIN_ROLE];
               stamp_irq_enable[ts] <= WDATA_I[`BIT_STAMP_IRQ];
            end else if (ADDR_I == `OFF_TARGET_NS && tu_ok) begin
               target_ns[tu] <= WDATA_I[29:0];
            end else if (ADDR_I == `OFF_TARGET_S && tu_ok) begin
               target_s[tu] <= WDATA_I;
            end else if (ADDR_I == `OFF_TRIG_NOTIFY && tu_ok) begin
               trig_notify[tu] <= WDATA_I[24];
            end
         end
         for (u = 0; u < 3; u = u + 1) begin
            if (WR_I && ADDR_I == `OFF_TRIG_STATUS && WDATA_I[u])
               trig_done[u] <= 1'b0;
            if (WR_I && ADDR_I == `OFF_TRIG_STATUS && WDATA_I[16 + u])
               trig_error[u] <= 1'b0;
            if (WR_I && ADDR_I == `OFF_IRQ_STATUS && WDATA_I[16 + u])
               trig_irq[u] <= 1'b0;
         end
         for (u = 0; u < 2; u = u + 1) begin
            if (WR_I && ADDR_I == `OFF_IRQ_STATUS && WDATA_I[u])
               stamp_irq[u] <= 1'b0;
            if (STAMP_EVENT_I[u] && stamp_unit_enable[u]) begin
               stamp_ready_flag[u] <= 1'b1;
               if (stamp_irq_enable[u])
                  stamp_irq[u] <= 1'b1;
               if (cnt_of(stamp_event_count, u[0]) == `STAMP_COUNT_MAX)
                  stamp_count_overflow[u] <= 1'b1;
               else if (u == 0)
                  stamp_event_count[3:0] <= stamp_event_count[3:0] + 4'h1;
               else
                  stamp_event_count[7:4] <= stamp_event_count[7:4] + 4'h1;
            end
         end
         if (tu_ok && trig_enable[tu] == 1'b0 && 1'b0)
            trig_enable[tu] <= 1'b0;
         for (u = 0; u < 3; u = u + 1) begin
            if (trig_enable[u] && u == tu && tu_ok) begin
               if (late && trig_notify[u] && !trig_error[u]) begin
                  trig_error[u] <= 1'b1;
                  trig_irq[u] <= 1'b1;
               end
            end
            if (trig_enable[u] && ((u == tu && due) || (u != tu))) begin
               if (u == tu) begin
                  trig_enable[u] <= 1'b0;
                  if (trig_notify[u]) begin
                     trig_done[u] <= 1'b1;
                     trig_irq[u] <= 1'b1;
                  end
               end
            end
         end
         if (wr_ctl && tu_ok) begin
            if (WDATA_I[`BIT_TRIG_CLEAR]) begin
               trig_enable[tu] <= 1'b0;
               trig_notify[tu] <= 1'b0;
               trig_error[tu] <= 1'b0;
               target_ns[tu] <= 30'h00000000;
               target_s[tu] <= 32'h00000000;
            end else begin
               trig_enable[tu] <= WDATA_I[`BIT_TRIG_ENABLE];
               if (!WDATA_I[`BIT_TRIG_ENABLE])
                  trig_error[tu] <= 1'b0;
            end
         end
         if (wr_ctl) begin
            if (WDATA_I[`BIT_STAMP_CLEAR]) begin
               stamp_unit_enable[ts] <= 1'b0;
               stamp_ready_flag[ts] <= 1'b0;
               stamp_count_overflow[ts] <= 1'b0;
               stamp_irq_enable[ts] <= 1'b0;
               if (ts)
                  stamp_event_count[7:4] <= 4'h0;
               else
                  stamp_event_count[3:0] <= 4'h0;
            end else if (WDATA_I[`BIT_STAMP_ENABLE]) begin
               stamp_unit_enable[ts] <= 1'b1;
               if (ts)
                  stamp_event_count[7:4] <= 4'h0;
               else
                  stamp_event_count[3:0] <= 4'h0;
            end else begin
               stamp_unit_enable[ts] <= 1'b0;
               stamp_ready_flag[ts] <= 1'b0;
               stamp_count_overflow[ts] <= 1'b0;
            end
         end
      end
   end

endmodule // ptp_global_control_regs
`default_nettype wire

/* File: testbench/ptp_global_control_regs_properties.sv */
`default_nettype none
module ptp_global_control_regs_properties (
   input wire logic        SYS_CLK_I,
   input wire logic        RST_N_I,
   input wire logic [11:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic        WR_I,
   input wire logic        RD_I,
   input wire logic [31:0] RDATA_O,
   input wire logic        BMC_KNOWN_I,
   input wire logic        FRAME_VALID_I,
   input wire logic        FRAME_IS_MCAST_I,
   input wire logic [3:0]  FRAME_MSG_TYPE_I,
   input wire logic [3:0]  FRAME_VERSION_I,
   input wire logic [7:0]  FRAME_DOMAIN_I,
   input wire logic        FRAME_IS_IPV6_I,
   input wire logic        FRAME_MODIFIED_I,
   input wire logic        IS_PTP_O,
   input wire logic        DROP_O,
   input wire logic        TOP_QUEUE_O,
   input wire logic        CAPTURE_O,
   input wire logic        CSUM_RECALC_O,
   input wire logic        PIN_OE_O,
   input wire logic        PIN_OUT_SEL_O,
   input wire logic        GLOBAL_IRQ_STATUS_O
);
   logic [15:0] cfg;
   logic [11:0] dv;
   logic        vld;
   assign vld = FRAME_VALID_I;
   // Shadow copies so frame checks know the programmed setup
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cfg <= 16'h1004;
         dv  <= 12'h200;
      end else if (WR_I) begin
         if (ADDR_I == 12'h516) cfg <= WDATA_I[15:0];
         if (ADDR_I == 12'h518) dv <= WDATA_I[11:0];
      end
   end
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   AST_READ_HOLD: assert property (!RD_I |=> $stable(RDATA_O))
      else $error("read data moved without a read");
   AST_IRQ_OR: assert property (RD_I && ADDR_I == 12'h528 |=>
      GLOBAL_IRQ_STATUS_O == (|RDATA_O[18:16] || |RDATA_O[1:0]))
      else $error("global status differs from unit bits");
   AST_PIN_BITS: assert property (WR_I && ADDR_I == 12'h52C ##1
      !(WR_I && ADDR_I == 12'h52C) |=> {PIN_OE_O, PIN_OUT_SEL_O} ==
      {$past(WDATA_I[6], 2), $past(WDATA_I[8], 2)})
      else $error("pin controls do not follow write");
   AST_UNICAST_OFF: assert property (vld && !cfg[12] && !FRAME_IS_MCAST_I |=> !IS_PTP_O)
      else $error("unicast seen as ptp while disabled");
   AST_PRIO_GENERAL: assert property (vld && !cfg[10] && FRAME_MSG_TYPE_I[3]
      |=> !TOP_QUEUE_O)
      else $error("general message sent to top queue");
   AST_DROP_NO_BMC: assert property (vld && cfg[5] && !BMC_KNOWN_I &&
      FRAME_MSG_TYPE_I inside {4'h0, 4'h1, 4'h8} |=> DROP_O || !IS_PTP_O)
      else $error("sync kept without best master");
   AST_VERSION: assert property (vld && FRAME_VERSION_I != dv[11:8] |=>
      !CAPTURE_O && (DROP_O || !IS_PTP_O))
      else $error("version mismatch not dropped");
   AST_DOMAIN: assert property (vld && cfg[4] && FRAME_DOMAIN_I != dv[7:0]
      |=> !CAPTURE_O)
      else $error("capture on domain mismatch");
   AST_CSUM_V6: assert property (vld && FRAME_MODIFIED_I && FRAME_IS_IPV6_I
      |=> CSUM_RECALC_O || DROP_O || !IS_PTP_O)
      else $error("ipv6 checksum not updated");
endmodule // ptp_global_control_regs_properties
bind ptp_global_control_regs ptp_global_control_regs_properties prop_u (
   .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
   .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .BMC_KNOWN_I(BMC_KNOWN_I),
   .FRAME_VALID_I(FRAME_VALID_I), .FRAME_IS_MCAST_I(FRAME_IS_MCAST_I),
   .FRAME_MSG_TYPE_I(FRAME_MSG_TYPE_I), .FRAME_VERSION_I(FRAME_VERSION_I),
   .FRAME_DOMAIN_I(FRAME_DOMAIN_I), .FRAME_IS_IPV6_I(FRAME_IS_IPV6_I),
   .FRAME_MODIFIED_I(FRAME_MODIFIED_I), .IS_PTP_O(IS_PTP_O), .DROP_O(DROP_O),
   .TOP_QUEUE_O(TOP_QUEUE_O), .CAPTURE_O(CAPTURE_O), .CSUM_RECALC_O(CSUM_RECALC_O),
   .PIN_OE_O(PIN_OE_O), .PIN_OUT_SEL_O(PIN_OUT_SEL_O),
   .GLOBAL_IRQ_STATUS_O(GLOBAL_IRQ_STATUS_O));
`default_nettype wire

/* File: testbench/ptp_global_control_regs_tb.sv */
`default_nettype none
module ptp_global_control_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, wr, rd, pin_in, bmc, vld, mc, v6, md, cz;
   logic        is_ptp, drop, to_host, top_q, cap, recalc, czero, pin_oe, pin_sel, girq;
   logic        fm, am, nonhost;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, rd_v;
   logic [63:0] tm;
   logic [15:0] port;
   logic [3:0]  typ, ver;
   logic [7:0]  dom;
   logic [1:0]  stamp;
   int          err_count, n_tests;
   logic [11:0] ra [9] = '{12'h516, 12'h518, 12'h520, 12'h524, 12'h528, 12'h52C,
                           12'h530, 12'h534, 12'h5FC};
   logic [31:0] rv [9] = '{32'h1004, 32'h200, 0, 0, 0, 0, 0, 0, 0};

   ptp_global_control_regs dut_u (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .PIN_IN_I(pin_in), .SYS_TIME_I(tm), .BMC_KNOWN_I(bmc),
      .FRAME_VALID_I(vld), .FRAME_IS_MCAST_I(mc), .FRAME_RESERVED_ADDR_I(1'b0),
      .FRAME_UDP_PORT_I(port), .FRAME_MSG_TYPE_I(typ), .FRAME_VERSION_I(ver),
      .FRAME_DOMAIN_I(dom), .FRAME_FROM_HOST_I(1'b0), .FRAME_FROM_MASTER_I(fm),
      .FRAME_ASSOC_MATCH_I(am), .FRAME_IS_IPV6_I(v6), .FRAME_MODIFIED_I(md),
      .FRAME_CSUM_ZERO_I(cz), .STAMP_EVENT_I(stamp), .IS_PTP_O(is_ptp), .DROP_O(drop),
      .TO_HOST_O(to_host), .TO_NONHOST_O(nonhost), .TOP_QUEUE_O(top_q), .CAPTURE_O(cap),
      .CSUM_RECALC_O(recalc), .CSUM_ZERO_O(czero), .PIN_OUT_O(), .PIN_OE_O(pin_oe),
      .PIN_OUT_SEL_O(pin_sel), .GLOBAL_IRQ_STATUS_O(girq));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({31'b0, got}, {31'b0, exp});
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rd_v = rdata;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      rd_reg(a);
      chk(rd_v, e);
   endtask
   // Flags are {multicast, ipv6, modified, zero checksum}
   task automatic frm(input logic [15:0] p, input logic [3:0] t, input logic [3:0] v,
                      input logic [7:0] d, input logic [3:0] f);
      @(posedge clk);
      vld <= 1'b1;
      port <= p;
      typ <= t;
      ver <= v;
      dom <= d;
      {mc, v6, md, cz} <= f;
      @(posedge clk);
      vld <= 1'b0;
      #1;
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk);
         stamp <= 2'b10;
         @(posedge clk);
         stamp <= 2'b00;
      end
   endtask
   // Status path is registered, so allow a few cycles
   task automatic wait_irq(input logic lvl);
      for (int i = 0; i < 20 && girq !== lvl; i++) @(posedge clk);
      if (girq !== lvl) begin
         err_count++;
         $display("mismatch at %0t: interrupt wait ran out", $time);
         print_verdict();
      end
      chkb(girq, lvl);
   endtask

   initial begin
      {rst_n, wr, rd, pin_in, bmc, vld, mc, v6, md, cz, fm, am} = '0;
      {addr, wdata, tm, port, typ, ver, dom, stamp} = '0;
      err_count = 0;
      n_tests = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ra[i]) rc(ra[i], rv[i]);
      wr_reg(12'h518, 32'hFFFFFFFF);
      rc(12'h518, 32'h0FFF);
      wr_reg(12'h520, 32'h102);
      rc(12'h520, 32'h102);
      wr_reg(12'h530, 32'hFFFFFFFF);
      wr_reg(12'h534, 32'hFFFFFFFF);
      rc(12'h530, 32'h3FFFFFFF);
      rc(12'h534, 32'hFFFFFFFF);
      wr_reg(12'h520, 32'h0);
      rc(12'h530, 32'h0);
      $display("test index done");
      tm <= {32'h0, 2'b00, 30'd50};
      wr_reg(12'h538, 32'h01000000);
      wr_reg(12'h530, 32'd100);
      wr_reg(12'h534, 32'h0);
      wr_reg(12'h52C, 32'h8);
      rc(12'h52C, 32'h18);
      tm <= {32'h0, 2'b00, 30'd100};
      wait_irq(1'b1);
      rc(12'h524, 32'h1);
      rc(12'h52C, 32'h0);
      rc(12'h528, 32'h10000);
      wr_reg(12'h524, 32'h0);
      rc(12'h524, 32'h1);
      wr_reg(12'h524, 32'h1);
      rc(12'h524, 32'h0);
      wr_reg(12'h528, 32'h10000);
      wait_irq(1'b0);
      $display("test trigger done");
      wr_reg(12'h520, 32'h1);
      wr_reg(12'h538, 32'h01000000);
      wr_reg(12'h530, 32'd10);
      wr_reg(12'h534, 32'h0);
      wr_reg(12'h52C, 32'h8);
      rd_reg(12'h524);
      chkb(rd_v[17], 1'b1);
      wr_reg(12'h52C, 32'h0);
      rd_reg(12'h524);
      chkb(rd_v[17], 1'b0);
      wr_reg(12'h524, 32'h70007);
      wr_reg(12'h528, 32'h70003);
      wr_reg(12'h520, 32'h2);
      // Target one second ahead so the unit stays armed
      wr_reg(12'h534, 32'h1);
      wr_reg(12'h52C, 32'h8);
      rc(12'h52C, 32'h18);
      wr_reg(12'h52C, 32'h4);
      rd_reg(12'h52C);
      chk({30'b0, rd_v[4:3]}, 32'h0);
      pin_in <= 1'b1;
      wr_reg(12'h52C, 32'h140);
      rc(12'h52C, 32'h1C0);
      chkb(pin_oe, 1'b1);
      chkb(pin_sel, 1'b1);
      wr_reg(12'h52C, 32'h0);
      $display("test error clear pin done");
      wr_reg(12'h520, 32'h100);
      wr_reg(12'h52C, 32'h22);
      pulse(17);
      rd_reg(12'h550);
      chk({27'b0, rd_v[20:16]}, 32'h1F);
      rd_reg(12'h528);
      chkb(rd_v[1], 1'b1);
      wr_reg(12'h52C, 32'h20);
      rd_reg(12'h550);
      chk({30'b0, rd_v[16:15]}, 32'h0);
      wr_reg(12'h52C, 32'h22);
      rd_reg(12'h550);
      chk({28'b0, rd_v[20:17]}, 32'h0);
      pulse(3);
      wr_reg(12'h52C, 32'h21);
      rd_reg(12'h550);
      chk({28'b0, rd_v[20:17]}, 32'h0);
      wr_reg(12'h528, 32'h3);
      $display("test stamp done");
      wr_reg(12'h518, 32'h200);
      frm(16'd319, 4'h0, 4'h2, 8'h0, 4'b0000);
      chkb(is_ptp, 1'b1);
      frm(16'd100, 4'h0, 4'h2, 8'h0, 4'b0000);
      chkb(is_ptp, 1'b0);
      wr_reg(12'h516, 32'h0004);
      frm(16'd320, 4'h0, 4'h2, 8'h0, 4'b0000);
      chkb(is_ptp, 1'b0);
      frm(16'd319, 4'h0, 4'h3, 8'h0, 4'b1000);
      chkb(drop, 1'b1);
      chkb(cap, 1'b0);
      wr_reg(12'h518, 32'h205);
      wr_reg(12'h516, 32'h0014);
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1000);
      chkb(to_host, 1'b1);
      chkb(cap, 1'b1);
      frm(16'd319, 4'h0, 4'h2, 8'h6, 4'b1000);
      chkb(drop, 1'b1);
      chkb(cap, 1'b0);
      wr_reg(12'h516, 32'h0004);
      frm(16'd320, 4'h8, 4'h2, 8'h5, 4'b1000);
      chkb(top_q, 1'b0);
      wr_reg(12'h516, 32'h0404);
      frm(16'd320, 4'h8, 4'h2, 8'h5, 4'b1000);
      chkb(top_q, 1'b1);
      wr_reg(12'h516, 32'h0024);
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1000);
      chkb(drop, 1'b1);
      bmc <= 1'b1;
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1000);
      chkb(drop, 1'b0);
      wr_reg(12'h516, 32'h0004);
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1010);
      chkb(recalc, 1'b1);
      wr_reg(12'h516, 32'h0);
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1010);
      chkb(czero, 1'b1);
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1011);
      chkb(recalc, 1'b0);
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1110);
      chkb(recalc, 1'b1);
      wr_reg(12'h516, 32'h0004);
      fm <= 1'b1;
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1000);
      chkb(to_host, 1'b0);
      chkb(nonhost, 1'b1);
      wr_reg(12'h516, 32'h0804);
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1000);
      chkb(to_host, 1'b1);
      wr_reg(12'h516, 32'h0204);
      am <= 1'b1;
      frm(16'd319, 4'h0, 4'h2, 8'h5, 4'b1000);
      chkb(to_host, 1'b1);
      $display("test frames done");
      print_verdict();
   end
endmodule // ptp_global_control_regs_tb
`default_nettype wire
